//--- hw/hrm_homing.sv
`timescale 1ns/100ps
module hrm_homing (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [15:0] par_addr_i,
    input wire logic par_wr_i,
    input wire logic par_rd_i,
    input wire logic [31:0] par_wdata_i,
    output logic [31:0] par_rdata_o,
    output logic par_ack_o,
    output logic par_err_o,
    input wire logic [15:0] ramp_speed_ceiling_i,
    input wire logic start_i,
    input wire logic stop_i,
    input wire logic switch_i,
    input wire logic index_i,
    input wire logic [31:0] pos_usr_i,
    input wire logic [31:0] pos_enc_i,
    output logic move_o,
    output logic dir_neg_o,
    output logic [15:0] speed_o,
    output logic set_pos_o,
    output logic [31:0] set_pos_value_o,
    output logic busy_o,
    output logic done_o,
    output logic fault_o
);
    typedef struct packed {
        hrm_pkg::hrm_state_e state;
        logic [15:0] method;
        logic [15:0] srch_spd;
        logic [15:0] leave_spd;
        logic [31:0] max_dist;
        logic [31:0] ref_dist;
        logic [31:0] home_pos;
        logic [31:0] setp_pos;
        logic [31:0] idx_dist;
        logic [31:0] edge_pos;
        logic [31:0] edge_enc;
        logic [31:0] det_pos;
        logic use_index;
        logic neg;
        logic [31:0] rdata;
        logic ack;
        logic err;
        logic move;
        logic dir_neg;
        logic [15:0] speed;
        logic set_pos;
        logic [31:0] set_val;
        logic busy;
        logic done;
        logic fault;
    } hrm_state_s;

    hrm_state_s s_reg;
    hrm_state_s s_next;

    function automatic logic [15:0] clamp_speed(input logic [15:0] spd,
                                                input logic [15:0] ceil);
        clamp_speed = (spd > ceil) ? ceil : spd;
    endfunction : clamp_speed

    function automatic logic [31:0] abs_diff(input logic [31:0] a, input logic [31:0] b);
        logic [31:0] d;
        d = a - b;
        abs_diff = d[31] ? (32'h0000_0000 - d) : d;
    endfunction : abs_diff

    function automatic logic spd_ok(input logic [31:0] v, input logic [15:0] hi);
        spd_ok = (v[31:16] == 16'h0000) && (v[15:0] >= hrm_pkg::SPD_MIN)
                 && (v[15:0] <= hi);
    endfunction : spd_ok

    always_comb begin
        s_next = s_reg;
        s_next.ack = 1'b0;
        s_next.err = 1'b0;
        s_next.set_pos = 1'b0;

        // Parameter access: one answer per request, the cycle after it
        if (par_rd_i || par_wr_i) begin
            s_next.ack = 1'b1;
            s_next.rdata = 32'h0000_0000;
        end
        if (par_rd_i) begin
            case (par_addr_i)
                hrm_pkg::ADDR_METHOD: s_next.rdata = {16'h0000, s_reg.method};
                hrm_pkg::ADDR_SETP_POS: s_next.rdata = s_reg.setp_pos;
                hrm_pkg::ADDR_SRCH_SPD: s_next.rdata = {16'h0000, s_reg.srch_spd};
                hrm_pkg::ADDR_LEAVE_SPD: s_next.rdata = {16'h0000, s_reg.leave_spd};
                hrm_pkg::ADDR_MAX_DIST: s_next.rdata = s_reg.max_dist;
                hrm_pkg::ADDR_REF_DIST: s_next.rdata = s_reg.ref_dist;
                hrm_pkg::ADDR_HOME_POS: s_next.rdata = s_reg.home_pos;
                hrm_pkg::ADDR_IDX_DIST: s_next.rdata = s_reg.idx_dist;
                default: s_next.err = 1'b1;
            endcase
        end else if (par_wr_i) begin
            case (par_addr_i)
                hrm_pkg::ADDR_METHOD: begin
                    if (s_reg.busy) begin
                        s_next.err = 1'b1;
                    end else begin
                        s_next.method = par_wdata_i[15:0];
                    end
                end
                hrm_pkg::ADDR_SETP_POS: s_next.setp_pos = par_wdata_i;
                hrm_pkg::ADDR_SRCH_SPD: begin
                    if (spd_ok(par_wdata_i, hrm_pkg::SRCH_SPD_MAX)) begin
                        s_next.srch_spd = par_wdata_i[15:0];
                    end else begin
                        s_next.err = 1'b1;
                    end
                end
                hrm_pkg::ADDR_LEAVE_SPD: begin
                    if (spd_ok(par_wdata_i, hrm_pkg::LEAVE_SPD_MAX)) begin
                        s_next.leave_spd = par_wdata_i[15:0];
                    end else begin
                        s_next.err = 1'b1;
                    end
                end
                hrm_pkg::ADDR_MAX_DIST: begin
                    if (!par_wdata_i[31]) begin
                        s_next.max_dist = par_wdata_i;
                    end else begin
                        s_next.err = 1'b1;
                    end
                end
                hrm_pkg::ADDR_REF_DIST: begin
                    if (!par_wdata_i[31] && par_wdata_i >= hrm_pkg::REF_DIST_MIN) begin
                        s_next.ref_dist = par_wdata_i;
                    end else begin
                        s_next.err = 1'b1;
                    end
                end
                hrm_pkg::ADDR_HOME_POS: s_next.home_pos = par_wdata_i;
                default: s_next.err = 1'b1;
            endcase
        end

        case (s_reg.state)
            hrm_pkg::HRM_IDLE: begin
                if (start_i) begin
                    s_next.fault = 1'b0;
                    s_next.done = 1'b0;
                    s_next.neg = s_reg.method[hrm_pkg::METHOD_DIR_BIT];
                    s_next.use_index = (s_reg.method <= hrm_pkg::METHOD_INDEX_LAST);
                    if (s_reg.method == hrm_pkg::METHOD_POS_SET) begin
                        s_next.set_pos = 1'b1;
                        s_next.set_val = s_reg.setp_pos;
                        s_next.done = 1'b1;
                    end else if (s_reg.method >= hrm_pkg::METHOD_FIRST
                                 && s_reg.method <= hrm_pkg::METHOD_LAST) begin
                        s_next.busy = 1'b1;
                        s_next.move = 1'b1;
                        s_next.dir_neg = s_reg.method[hrm_pkg::METHOD_DIR_BIT];
                        s_next.state = hrm_pkg::HRM_SEARCH;
                    end else begin
                        s_next.fault = 1'b1;
                    end
                end
            end
            hrm_pkg::HRM_SEARCH: begin
                s_next.speed = clamp_speed(s_reg.srch_spd, ramp_speed_ceiling_i);
                if (switch_i) begin
                    // Switch found: reverse and back out slowly
                    s_next.det_pos = pos_usr_i;
                    s_next.dir_neg = !s_reg.neg;
                    s_next.speed = clamp_speed(s_reg.leave_spd, ramp_speed_ceiling_i);
                    s_next.state = hrm_pkg::HRM_LEAVE;
                end
            end
            hrm_pkg::HRM_LEAVE: begin
                s_next.speed = clamp_speed(s_reg.leave_spd, ramp_speed_ceiling_i);
                if (!switch_i) begin
                    s_next.edge_pos = pos_usr_i;
                    s_next.edge_enc = pos_enc_i;
                    if (s_reg.use_index) begin
                        s_next.state = hrm_pkg::HRM_INDEX;
                    end else begin
                        s_next.state = hrm_pkg::HRM_OFFSET;
                    end
                end else if (s_reg.max_dist != 32'h0000_0000
                             && abs_diff(pos_usr_i, s_reg.det_pos) > s_reg.max_dist) begin
                    s_next.move = 1'b0;
                    s_next.speed = 16'h0000;
                    s_next.busy = 1'b0;
                    s_next.fault = 1'b1;
                    s_next.state = hrm_pkg::HRM_IDLE;
                end
            end
            hrm_pkg::HRM_INDEX: begin
                // Follow a lowered ramp ceiling while creeping away from the edge
                s_next.speed = clamp_speed(s_reg.leave_spd, ramp_speed_ceiling_i);
                if (index_i) begin
                    s_next.idx_dist = pos_enc_i - s_reg.edge_enc;
                    s_next.move = 1'b0;
                    s_next.speed = 16'h0000;
                    s_next.state = hrm_pkg::HRM_HOME;
                end
            end
            hrm_pkg::HRM_OFFSET: begin
                s_next.speed = clamp_speed(s_reg.leave_spd, ramp_speed_ceiling_i);
                if (abs_diff(pos_usr_i, s_reg.edge_pos) >= s_reg.ref_dist) begin
                    s_next.move = 1'b0;
                    s_next.speed = 16'h0000;
                    s_next.state = hrm_pkg::HRM_HOME;
                end
            end
            hrm_pkg::HRM_HOME: begin
                s_next.set_pos = 1'b1;
                s_next.set_val = s_reg.home_pos;
                s_next.busy = 1'b0;
                s_next.done = 1'b1;
                s_next.state = hrm_pkg::HRM_IDLE;
            end
            default: begin
                s_next.state = hrm_pkg::HRM_IDLE;
            end
        endcase

        // Cancel stops any running movement without setting a position
        if (stop_i && s_reg.busy) begin
            s_next.move = 1'b0;
            s_next.speed = 16'h0000;
            s_next.busy = 1'b0;
            s_next.set_pos = 1'b0;
            s_next.done = 1'b0;
            s_next.state = hrm_pkg::HRM_IDLE;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_reg <= '0;
            s_reg.state <= hrm_pkg::HRM_IDLE;
            s_reg.method <= hrm_pkg::RST_METHOD;
            s_reg.srch_spd <= hrm_pkg::RST_SRCH_SPD;
            s_reg.leave_spd <= hrm_pkg::RST_LEAVE_SPD;
            s_reg.max_dist <= hrm_pkg::RST_MAX_DIST;
            s_reg.ref_dist <= hrm_pkg::RST_REF_DIST;
            s_reg.home_pos <= hrm_pkg::RST_HOME_POS;
            s_reg.setp_pos <= hrm_pkg::RST_SETP_POS;
        end else if (ce_i) begin
            s_reg <= s_next;
        end
    end

    assign par_rdata_o = s_reg.rdata;
    assign par_ack_o = s_reg.ack;
    assign par_err_o = s_reg.err;
    assign move_o = s_reg.move;
    assign dir_neg_o = s_reg.dir_neg;
    assign speed_o = s_reg.speed;
    assign set_pos_o = s_reg.set_pos;
    assign set_pos_value_o = s_reg.set_val;
    assign busy_o = s_reg.busy;
    assign done_o = s_reg.done;
    assign fault_o = s_reg.fault;
endmodule : hrm_homing

//--- hw/hrm_pkg.sv
// Behaviour
// - Read-only signed index-to-edge distance, 1/10000 rev
// - Leave switch, move refpoint distance, min 1
// - Refpoint distance ignored when index pulse processing
// - Search speed 1..13200, default 60, clamped
// - Leave speed 1..3000, default 6, clamped
// - Max edge search distance zero disables monitoring
// - Edge not found within distance: cancel, error
// - On success load home position value
// - Method 35 sets position without searching
package hrm_pkg;
    localparam logic [15:0] ADDR_METHOD = 16'h1b18;
    localparam logic [15:0] ADDR_SETP_POS = 16'h1b2c;
    localparam logic [15:0] ADDR_SRCH_SPD = 16'h2808;
    localparam logic [15:0] ADDR_LEAVE_SPD = 16'h280a;
    localparam logic [15:0] ADDR_MAX_DIST = 16'h280c;
    localparam logic [15:0] ADDR_REF_DIST = 16'h280e;
    localparam logic [15:0] ADDR_HOME_POS = 16'h2816;
    localparam logic [15:0] ADDR_IDX_DIST = 16'h2818;

    localparam logic [15:0] RST_METHOD = 16'h0012;
    localparam logic [15:0] RST_SRCH_SPD = 16'h003c;
    localparam logic [15:0] RST_LEAVE_SPD = 16'h0006;
    localparam logic [31:0] RST_MAX_DIST = 32'h0000_0000;
    localparam logic [31:0] RST_REF_DIST = 32'h0000_00c8;
    localparam logic [31:0] RST_HOME_POS = 32'h0000_0000;
    localparam logic [31:0] RST_SETP_POS = 32'h0000_0000;

    localparam logic [15:0] SPD_MIN = 16'h0001;
    localparam logic [15:0] SRCH_SPD_MAX = 16'h3390;
    localparam logic [15:0] LEAVE_SPD_MAX = 16'h0bb8;
    localparam logic [31:0] REF_DIST_MIN = 32'h0000_0001;

    localparam logic [15:0] METHOD_POS_SET = 16'h0023;
    localparam logic [15:0] METHOD_FIRST = 16'h0001;
    localparam logic [15:0] METHOD_LAST = 16'h0022;
    localparam logic [15:0] METHOD_INDEX_LAST = 16'h000e;
    localparam int METHOD_DIR_BIT = 0;

    typedef enum logic [2:0] {
        HRM_IDLE,
        HRM_SEARCH,
        HRM_LEAVE,
        HRM_INDEX,
        HRM_OFFSET,
        HRM_HOME
    } hrm_state_e;
endpackage : hrm_pkg

//--- tb/hrm_axis_model.sv
`timescale 1ns/100ps
module hrm_axis_model (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic move_i,
    input wire logic dir_neg_i,
    input wire logic stuck_i,
    output logic switch_o,
    output logic index_o,
    output logic [31:0] pos_usr_o,
    output logic [31:0] pos_enc_o
);
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i)
            pos_usr_o <= '0;
        else if (move_i)
            pos_usr_o <= dir_neg_i ? pos_usr_o - 32'd1 : pos_usr_o + 32'd1;
    end
    // Limit switches at both ends of travel; stuck models a switch that never releases
    assign switch_o = stuck_i || $signed(pos_usr_o) >= 20 || $signed(pos_usr_o) <= -20;
    assign index_o = pos_usr_o[3:0] == 4'h0;
    assign pos_enc_o = pos_usr_o * 32'd100;
endmodule : hrm_axis_model

//--- tb/hrm_homing_props.sv
`timescale 1ns/100ps
module hrm_homing_props (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [15:0] par_addr_i,
    input wire logic par_wr_i,
    input wire logic par_rd_i,
    input wire logic par_ack_o,
    input wire logic par_err_o,
    input wire logic [15:0] ramp_speed_ceiling_i,
    input wire logic start_i,
    input wire logic move_o,
    input wire logic [15:0] speed_o,
    input wire logic set_pos_o,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic fault_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    a_ack_after_req: assert property (ce_i && (par_rd_i || par_wr_i) ##1 ce_i |-> par_ack_o)
        else $error("request not acknowledged");
    a_ro_write_err: assert property (ce_i && par_wr_i && !par_rd_i && par_addr_i == 16'h2818
        ##1 ce_i |-> par_err_o && par_ack_o)
        else $error("write to read-only distance accepted");
    a_speed_clamped: assert property (move_o && speed_o != 16'h0
        |-> speed_o <= $past(ramp_speed_ceiling_i))
        else $error("speed above ramp ceiling");
    a_speed_top: assert property (speed_o <= 16'h3390)
        else $error("speed above search maximum");
    a_still_no_speed: assert property (!move_o |-> speed_o == 16'h0)
        else $error("speed without motion");
    a_home_load_pulse: assert property (set_pos_o |-> done_o && !busy_o ##1 !set_pos_o)
        else $error("position load not a single pulse at completion");
    a_fault_halts: assert property (fault_o |-> !move_o && !done_o && !busy_o)
        else $error("motion or success after cancel");
    a_busy_by_start: assert property ($rose(busy_o) |-> $past(start_i))
        else $error("homing began without start");
    c_load: cover property (set_pos_o);
    c_fault: cover property ($rose(fault_o));
    c_refuse: cover property (par_err_o);
endmodule : hrm_homing_props
bind hrm_homing hrm_homing_props i_hrm_homing_props (.clk_i, .resetn_i, .ce_i, .par_addr_i,
    .par_wr_i, .par_rd_i, .par_ack_o, .par_err_o, .ramp_speed_ceiling_i, .start_i, .move_o,
    .speed_o, .set_pos_o, .busy_o, .done_o, .fault_o);

//--- tb/test_hrm_homing.sv
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module test_hrm_homing;
    logic clk_i = 0, resetn_i = 0, rd = 0, wr = 0, start = 0, stop = 0, stuck = 0;
    logic [15:0] addr = '0, ceil = 16'h1000, spd;
    logic [31:0] wdata = '0, rdata, sval, pos, enc, r, v, k;
    logic ack, err, move, dneg, setp, busy, done, fault, sw, idx;
    int error_cnt = 0, n_compared = 0, seed = 96;
    logic [15:0] ta[10] = '{16'h2818, 16'h2808, 16'h2808, 16'h2808, 16'h280a, 16'h280a,
        16'h280e, 16'h280e, 16'h280c, 16'h1234};
    logic [31:0] td[10] = '{5, 13200, 0, 13201, 3001, 3000, 0, 1, 32'hffff_ffff, 0};
    logic te[10] = '{1, 0, 1, 1, 1, 0, 1, 0, 1, 1};
    logic [31:0] dv[6] = '{32'h12, 32'h3c, 32'h6, 32'h0, 32'hc8, 32'h0};
    logic [15:0] da[6] = '{16'h1b18, 16'h2808, 16'h280a, 16'h280c, 16'h280e, 16'h2816};
    always #12.5 clk_i = ~clk_i;
    hrm_homing i_hrm_homing (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1), .par_addr_i(addr),
        .par_wr_i(wr), .par_rd_i(rd), .par_wdata_i(wdata), .par_rdata_o(rdata), .par_ack_o(ack),
        .par_err_o(err), .ramp_speed_ceiling_i(ceil), .start_i(start), .stop_i(stop),
        .switch_i(sw), .index_i(idx), .pos_usr_i(pos), .pos_enc_i(enc), .move_o(move),
        .dir_neg_o(dneg), .speed_o(spd), .set_pos_o(setp), .set_pos_value_o(sval),
        .busy_o(busy), .done_o(done), .fault_o(fault));
    hrm_axis_model i_hrm_axis_model (.clk_i(clk_i), .resetn_i(resetn_i), .move_i(move),
        .dir_neg_i(dneg), .stuck_i(stuck), .switch_o(sw), .index_o(idx), .pos_usr_o(pos),
        .pos_enc_o(enc));
    function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
        return (a < b) ? a : b;
    endfunction : min16
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask : tick
    task automatic par(input logic rd_q, input logic [15:0] a, input logic [31:0] d,
                       input logic e);
        addr = a;
        rd = rd_q;
        wr = !rd_q;
        wdata = d;
        tick(1);
        r = rdata;
        `CHK(ack, 1'b1)
        `CHK(err, e)
        rd = 1'b0;
        wr = 1'b0;
        tick(1);
    endtask : par
    task automatic run(input logic [15:0] m);
        par(0, hrm_pkg::ADDR_METHOD, {16'h0, m}, 1'b0);
        start = 1'b1;
        tick(1);
        start = 1'b0;
    endtask : run
    task automatic wait_idle;
        for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge clk_i);
        #2;
        `CHK(busy, 1'b0)
    endtask : wait_idle
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    initial begin
        #(25 * 20000);
        error_cnt++;
        wrap_up();
    end
    initial begin
        tick(8);
        resetn_i = 1'b1;
        for (int i = 0; i < 6; i++) begin
            par(1, da[i], 0, 1'b0);
            `CHK(r, dv[i])
        end
        for (int i = 0; i < 10; i++) par(0, ta[i], td[i], te[i]);
        par(1, hrm_pkg::ADDR_SRCH_SPD, 0, 1'b0);
        `CHK(r, 32'h3390)
        ceil = 16'({$random(seed)} % 16000 + 1);
        v = {$random(seed)} % 13200 + 1;
        k = $random(seed);
        par(0, hrm_pkg::ADDR_SRCH_SPD, v, 1'b0);
        par(0, hrm_pkg::ADDR_REF_DIST, 5, 1'b0);
        par(0, hrm_pkg::ADDR_HOME_POS, k, 1'b0);
        run(18);
        tick(3);
        `CHK(spd, min16(v[15:0], ceil))
        wait_idle();
        `CHK(done, 1'b1)
        `CHK(sval, k)
        `CHK(($signed(pos) >= 12 && $signed(pos) <= 14), 1'b1)
        par(0, hrm_pkg::ADDR_REF_DIST, 1, 1'b0);
        run(1);
        wait_idle();
        `CHK(($signed(pos) >= -16 && $signed(pos) <= -15), 1'b1)
        par(1, hrm_pkg::ADDR_IDX_DIST, 0, 1'b0);
        `CHK(($signed(r) >= 200 && $signed(r) <= 400), 1'b1)
        v = {$random(seed)} % 3000 + 1;
        par(0, hrm_pkg::ADDR_LEAVE_SPD, v, 1'b0);
        stuck = 1'b1;
        run(18);
        tick(5);
        `CHK(spd, min16(v[15:0], ceil))
        `CHK(dneg, 1'b1)
        par(0, hrm_pkg::ADDR_METHOD, 18, 1'b1);
        tick(60);
        `CHK({busy, fault}, 2'b10)
        stop = 1'b1;
        tick(1);
        stop = 1'b0;
        wait_idle();
        par(0, hrm_pkg::ADDR_MAX_DIST, 10, 1'b0);
        run(18);
        tick(30);
        `CHK({busy, move, fault, done}, 4'b0010)
        stuck = 1'b0;
        v = $random(seed);
        par(0, hrm_pkg::ADDR_SETP_POS, v, 1'b0);
        run(35);
        `CHK({setp, move, done}, 3'b101)
        `CHK(sval, v)
        wrap_up();
    end
endmodule : test_hrm_homing
